// >>> src/dcc_pkg.sv
// Package: shared types and constants for the dual channel sample capture
`default_nettype none
package dcc_pkg;
  localparam int unsigned DATA_W = 12;
  localparam int unsigned FIFO_DEPTH = 4;
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned WAKE_PULSE_NS = 25;
  localparam int unsigned WAKE_PULSE_CYC =
    (WAKE_PULSE_NS * CLK_MHZ + 999) / 1000 < 1 ? 1 :
    (WAKE_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam logic [DATA_W-1:0] CODE_RST = 12'h000;
  localparam logic [DATA_W-1:0] CODE_FULL = 12'hfff;
  localparam logic SLEEP_LOW_RST = 1'b1;

  typedef struct packed {
    logic [DATA_W-1:0] chan_a;
    logic [DATA_W-1:0] chan_b;
  } dcc_pair_s;

  typedef enum logic [1:0] {
    DCC_ASLEEP,
    DCC_WAKING,
    DCC_RUN
  } dcc_state_e;
endpackage : dcc_pkg
`default_nettype wire

// >>> src/dcc_fifo.sv
// Module: small synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module dcc_fifo #(
  parameter int unsigned WIDTH = 24,
  parameter int unsigned DEPTH = 4
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  output logic [WIDTH-1:0] rd_data_out,
  output logic rd_valid_out,
  input wire logic rd_ready_in
);
  localparam int unsigned AW = (DEPTH < 2) ? 1 : $clog2(DEPTH);

  // Pointer wrap relies on a power-of-two depth
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("dcc_fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0] wr_ptr_reg;
  logic [AW:0] rd_ptr_reg;
  wire full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
              (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  wire empty = (wr_ptr_reg == rd_ptr_reg);
  wire push = wr_valid_in && !full;
  wire pop = rd_ready_in && !empty;

  // Handshakes are combinational from the pointers
  assign wr_ready_out = !full;
  assign rd_valid_out = !empty;
  assign rd_data_out = mem_reg[rd_ptr_reg[AW-1:0]];

  // Storage has no reset; only the pointers define validity
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_reg[wr_ptr_reg[AW-1:0]] <= wr_data_in;
    end
  end

  // Pointer update
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end
endmodule : dcc_fifo
`default_nettype wire

// >>> src/dcc_capture.sv
// Module: DDR interleaved two-channel sample capture and conversion pacing
`timescale 1ns/1ps
`default_nettype none
// Operation
// R1: Both channels arrive on one shared bus up to 12 bits wide and are captured from it.
// R2: A word is captured on each rising and each falling edge of the conversion clock.
// R3: The source sends A0, B0, A1, B1 strictly alternating, channel A first.
// R4: The conversion clock paces conversion, one A and one B sample per cycle.
// R5: Each word is unsigned offset binary, zero minimum, all ones full scale.
// R6: An undriven sleep input reads high, so the device is awake.
// R7: The source pulses sleep low for at least 25 ns before sending data; the code needs three low pin samples, so a 40 ns pulse is short.
// R8: The rising edge word is channel A and the next falling edge word is B.
module dcc_capture #(
  parameter int unsigned DATA_W = dcc_pkg::DATA_W,
  parameter int unsigned FIFO_DEPTH = dcc_pkg::FIFO_DEPTH
) (
  input wire logic CORE_CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic CONVERSION_CLOCK_IN,
  input wire logic [DATA_W-1:0] BUS_DATA_IN,
  input wire logic SLEEP_REQUEST_LOW_IN,
  input wire logic SLEEP_DRIVEN_IN,
  output logic [DATA_W-1:0] CURRENT_OUTPUT_TRUE_A_OUT,
  output logic [DATA_W-1:0] CURRENT_OUTPUT_COMPLEMENT_A_OUT,
  output logic [DATA_W-1:0] CURRENT_OUTPUT_TRUE_B_OUT,
  output logic [DATA_W-1:0] CURRENT_OUTPUT_COMPLEMENT_B_OUT,
  output logic CONVERT_STROBE_OUT,
  output logic AWAKE_OUT,
  output logic OVERFLOW_OUT
);
  // Widths beyond the bus or below one bit have no meaning here
  if (DATA_W < 1 || DATA_W > 12) begin : g_bad_width
    $error("dcc_capture data width must be 1 to 12 bits");
  end

  localparam int unsigned PW = 2 * DATA_W;

  // Three-stage synchronisers for the conversion clock and sleep pin
  logic [2:0] clk_sync_reg;
  logic [2:0] sleep_sync_reg;
  logic [DATA_W-1:0] data_s1_reg;
  logic [DATA_W-1:0] data_s2_reg;
  logic [DATA_W-1:0] data_s3_reg;

  // Undriven sleep pin is treated as high, as a pull-up would hold it
  wire sleep_pin = SLEEP_DRIVEN_IN ? SLEEP_REQUEST_LOW_IN : 1'b1; // R6

  always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      clk_sync_reg <= 3'h0;
      sleep_sync_reg <= {3{dcc_pkg::SLEEP_LOW_RST}};
      data_s1_reg <= '0;
      data_s2_reg <= '0;
      data_s3_reg <= '0;
    end else begin
      clk_sync_reg <= {clk_sync_reg[1:0], CONVERSION_CLOCK_IN};
      sleep_sync_reg <= {sleep_sync_reg[1:0], sleep_pin};
      data_s1_reg <= BUS_DATA_IN; // R1
      data_s2_reg <= data_s1_reg;
      data_s3_reg <= data_s2_reg;
    end
  end

  // Filtered conversion clock level: it follows the pin only once stages
  // two and three agree, so a sample caught mid-transition never counts
  logic clk_level_reg;
  wire clk_agree = (clk_sync_reg[1] == clk_sync_reg[2]);
  wire clk_rise = clk_agree && clk_sync_reg[2] && !clk_level_reg;
  wire clk_fall = clk_agree && !clk_sync_reg[2] && clk_level_reg;

  // Level resets low like the idle clock, so reset brings no false edge
  always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      clk_level_reg <= 1'b0;
    end else if (clk_agree) begin
      clk_level_reg <= clk_sync_reg[2];
    end
  end

  // Sleep changes count once stages two and three agree
  wire sleep_low = !sleep_sync_reg[1] && !sleep_sync_reg[2];
  wire sleep_high = sleep_sync_reg[1] && sleep_sync_reg[2];
  // Third data stage lines up with the filtered edge decision, which
  // sees the clock one stage later than the raw synchroniser would
  wire [DATA_W-1:0] word_now = data_s3_reg;

  // Wake sequencing: a low pulse seen on at least WAKE_PULSE_CYC + 1 pin samples arms capture
  dcc_pkg::dcc_state_e state_reg;
  dcc_pkg::dcc_state_e state_next;
  logic [7:0] pulse_cnt_reg;
  logic [7:0] pulse_cnt_next;
  wire pulse_long = pulse_cnt_reg >= 8'(dcc_pkg::WAKE_PULSE_CYC);

  always_comb begin
    state_next = state_reg;
    pulse_cnt_next = pulse_cnt_reg;
    unique case (state_reg)
      dcc_pkg::DCC_ASLEEP: begin
        pulse_cnt_next = 8'h00;
        // The first low cycle already counts toward the pulse length
        if (sleep_low) begin
          state_next = dcc_pkg::DCC_WAKING;
          pulse_cnt_next = 8'h01;
        end
      end
      dcc_pkg::DCC_WAKING: begin
        if (sleep_low && !pulse_long) pulse_cnt_next = pulse_cnt_reg + 8'h01;
        if (sleep_high) begin
          state_next = pulse_long ? dcc_pkg::DCC_RUN : dcc_pkg::DCC_ASLEEP; // R7
        end
      end
      dcc_pkg::DCC_RUN: begin
        if (sleep_low) begin
          state_next = dcc_pkg::DCC_WAKING;
          pulse_cnt_next = 8'h01;
        end
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      state_reg <= dcc_pkg::DCC_RUN; // R6
      pulse_cnt_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      pulse_cnt_reg <= pulse_cnt_next;
    end
  end

  wire running = (state_reg == dcc_pkg::DCC_RUN);
  assign AWAKE_OUT = running;

  // Rising edge word is held as channel A until the falling edge brings B
  logic [DATA_W-1:0] chan_a_reg;
  logic have_a_reg;
  wire pair_done = running && clk_fall && have_a_reg; // R8

  always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      chan_a_reg <= '0;
      have_a_reg <= 1'b0;
    end else if (!running) begin
      have_a_reg <= 1'b0;
    end else if (clk_rise) begin
      chan_a_reg <= word_now; // R2
      have_a_reg <= 1'b1; // R3
    end else if (clk_fall) begin
      have_a_reg <= 1'b0; // R2
    end
  end

  // Pairs queue here; conversion drains one pair per rising edge. Each rise
  // pops before the next fall pushes, so in steady flow one pair waits.
  logic [PW-1:0] fifo_out;
  logic fifo_valid;
  logic fifo_ready_wr;
  wire convert_tick = running && clk_rise; // R4
  wire [PW-1:0] pair_word = {chan_a_reg, word_now}; // R1

  dcc_fifo #(
    .WIDTH(PW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_in(CORE_CLK_IN),
    .rst_in(SYS_RST_IN),
    .wr_data_in(pair_word),
    .wr_valid_in(pair_done),
    .wr_ready_out(fifo_ready_wr),
    .rd_data_out(fifo_out),
    .rd_valid_out(fifo_valid),
    .rd_ready_in(convert_tick)
  );

  // The source cannot be stalled, so a full queue drops the pair and flags it
  logic overflow_reg;
  always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      overflow_reg <= 1'b0;
    end else if (pair_done && !fifo_ready_wr) begin
      overflow_reg <= 1'b1;
    end else if (!running) begin
      overflow_reg <= 1'b0;
    end
  end
  assign OVERFLOW_OUT = overflow_reg;

  // Offset binary: complement output follows the code, true is all ones minus
  wire [DATA_W-1:0] code_a = fifo_out[PW-1:DATA_W];
  wire [DATA_W-1:0] code_b = fifo_out[DATA_W-1:0];
  wire [DATA_W-1:0] full_code = dcc_pkg::CODE_FULL[DATA_W-1:0];

  logic [DATA_W-1:0] true_a_reg;
  logic [DATA_W-1:0] comp_a_reg;
  logic [DATA_W-1:0] true_b_reg;
  logic [DATA_W-1:0] comp_b_reg;
  logic strobe_reg;

  // Output stage; codes hold between conversions and while asleep
  always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      true_a_reg <= dcc_pkg::CODE_RST[DATA_W-1:0];
      comp_a_reg <= dcc_pkg::CODE_FULL[DATA_W-1:0];
      true_b_reg <= dcc_pkg::CODE_RST[DATA_W-1:0];
      comp_b_reg <= dcc_pkg::CODE_FULL[DATA_W-1:0];
      strobe_reg <= 1'b0;
    end else begin
      strobe_reg <= convert_tick && fifo_valid; // R4
      if (convert_tick && fifo_valid) begin
        true_a_reg <= full_code - code_a; // R5
        comp_a_reg <= code_a; // R5
        true_b_reg <= full_code - code_b;
        comp_b_reg <= code_b;
      end
    end
  end

  assign CURRENT_OUTPUT_TRUE_A_OUT = true_a_reg;
  assign CURRENT_OUTPUT_COMPLEMENT_A_OUT = comp_a_reg;
  assign CURRENT_OUTPUT_TRUE_B_OUT = true_b_reg;
  assign CURRENT_OUTPUT_COMPLEMENT_B_OUT = comp_b_reg;
  assign CONVERT_STROBE_OUT = strobe_reg;
endmodule : dcc_capture
`default_nettype wire

// >>> dv/dcc_capture_checker.sv
// Checker: port-level assertions for the sample capture block
`timescale 1ns/1ps
`default_nettype none
module dcc_capture_checker #(
  parameter int unsigned DATA_W = 12
) (
  input wire logic CORE_CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic CONVERSION_CLOCK_IN,
  input wire logic SLEEP_REQUEST_LOW_IN,
  input wire logic SLEEP_DRIVEN_IN,
  input wire logic [DATA_W-1:0] CURRENT_OUTPUT_TRUE_A_OUT,
  input wire logic [DATA_W-1:0] CURRENT_OUTPUT_COMPLEMENT_A_OUT,
  input wire logic [DATA_W-1:0] CURRENT_OUTPUT_TRUE_B_OUT,
  input wire logic [DATA_W-1:0] CURRENT_OUTPUT_COMPLEMENT_B_OUT,
  input wire logic CONVERT_STROBE_OUT,
  input wire logic AWAKE_OUT
);
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  // One conversion per clock period, so the strobe never stretches
  a_strobe_single: assert property (
    CONVERT_STROBE_OUT |=> !CONVERT_STROBE_OUT) else $error("long strobe");
  // The two output nodes always share the full scale
  a_code_pair_a: assert property (
    CURRENT_OUTPUT_TRUE_A_OUT == ~CURRENT_OUTPUT_COMPLEMENT_A_OUT)
    else $error("channel A nodes disagree");
  a_code_pair_b: assert property (
    CURRENT_OUTPUT_TRUE_B_OUT == ~CURRENT_OUTPUT_COMPLEMENT_B_OUT)
    else $error("channel B nodes disagree");
  a_hold_between: assert property (
    !CONVERT_STROBE_OUT |-> $stable(CURRENT_OUTPUT_COMPLEMENT_A_OUT) &&
    $stable(CURRENT_OUTPUT_COMPLEMENT_B_OUT)) else $error("output moved");
  // A pair only leaves on a rising conversion edge
  a_strobe_on_high: assert property (
    CONVERT_STROBE_OUT |-> $past(CONVERSION_CLOCK_IN, 2))
    else $error("strobe without rising edge");
  // A pin that reads high, driven or pulled up, keeps the part awake
  a_awake_held: assert property (
    (!SLEEP_DRIVEN_IN || SLEEP_REQUEST_LOW_IN)[*4] ##0 AWAKE_OUT
    |=> AWAKE_OUT) else $error("awake dropped");
  a_sleep_drops: assert property (
    (SLEEP_DRIVEN_IN && !SLEEP_REQUEST_LOW_IN)[*5] |=> !AWAKE_OUT)
    else $error("still awake while held low");
endmodule : dcc_capture_checker
bind dcc_capture dcc_capture_checker #(.DATA_W(DATA_W)) dcc_capture_checker_i (
  .CORE_CLK_IN, .SYS_RST_IN, .CONVERSION_CLOCK_IN, .SLEEP_REQUEST_LOW_IN,
  .SLEEP_DRIVEN_IN, .CURRENT_OUTPUT_TRUE_A_OUT,
  .CURRENT_OUTPUT_COMPLEMENT_A_OUT, .CURRENT_OUTPUT_TRUE_B_OUT,
  .CURRENT_OUTPUT_COMPLEMENT_B_OUT, .CONVERT_STROBE_OUT, .AWAKE_OUT);
`default_nettype wire

// >>> dv/dcc_source.sv
// Partner: sample source driving conversion clock, bus and sleep pin
`timescale 1ns/1ps
`default_nettype none
module dcc_source (
  input wire logic clk_in,
  output logic conv_clk_out,
  output logic [dcc_pkg::DATA_W-1:0] bus_out,
  output logic sleep_low_out,
  output logic sleep_driven_out
);
  // Clock stands still outside frames; pin starts undriven
  initial begin
    conv_clk_out = 1'b0;
    bus_out = 12'h000;
    sleep_low_out = 1'b0;
    sleep_driven_out = 1'b0;
  end
  // Low pulse of n core cycles, then the pin is held high
  task automatic sleep_pulse(input int n);
    @(negedge clk_in);
    sleep_driven_out = 1'b1;
    sleep_low_out = 1'b0;
    repeat (n) @(negedge clk_in);
    sleep_low_out = 1'b1;
  endtask : sleep_pulse
  // Let go of the pin; the stale level left behind is the inverse, so
  // only the pull-up can keep the part awake
  task automatic release_sleep();
    @(negedge clk_in);
    sleep_driven_out = 1'b0;
    sleep_low_out = 1'b0;
  endtask : release_sleep
  // One pair: A held over the high phase, B over the low phase
  task automatic send_pair(input logic [11:0] a, input logic [11:0] b);
    conv_clk_out = 1'b1;
    bus_out = a;
    repeat (4) @(negedge clk_in);
    conv_clk_out = 1'b0;
    bus_out = b;
    repeat (4) @(negedge clk_in);
  endtask : send_pair
endmodule : dcc_source
`default_nettype wire

// >>> dv/dcc_capture_tb.sv
// Testbench: reset, stream and sleep checks for the sample capture block
`timescale 1ns/1ps
`default_nettype none
module dcc_capture_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic conv, slp_low, slp_drv, strobe, awake, ovf;
  logic [11:0] bus, ta, ca, tb, cb;
  logic [23:0] exp_q[$];
  bit exp_awake = 1'b1;
  int err_total = 0;
  int n_compared = 0;
  initial begin
    forever #10 clk = ~clk;
  end
  dcc_source dcc_source_i (.clk_in(clk), .conv_clk_out(conv),
    .bus_out(bus), .sleep_low_out(slp_low), .sleep_driven_out(slp_drv));
  dcc_capture dcc_capture_i (.CORE_CLK_IN(clk), .SYS_RST_IN(rst),
    .CONVERSION_CLOCK_IN(conv), .BUS_DATA_IN(bus),
    .SLEEP_REQUEST_LOW_IN(slp_low), .SLEEP_DRIVEN_IN(slp_drv),
    .CURRENT_OUTPUT_TRUE_A_OUT(ta), .CURRENT_OUTPUT_COMPLEMENT_A_OUT(ca),
    .CURRENT_OUTPUT_TRUE_B_OUT(tb), .CURRENT_OUTPUT_COMPLEMENT_B_OUT(cb),
    .CONVERT_STROBE_OUT(strobe), .AWAKE_OUT(awake), .OVERFLOW_OUT(ovf));
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Each strobe must carry the oldest pair sent while awake
  always @(negedge clk) begin
    if (strobe === 1'b1) begin
      chk({ta, tb}, ~exp_q[0]);
      chk({ca, cb}, exp_q.pop_front());
    end
  end
  task automatic send(input logic [11:0] a, input logic [11:0] b);
    if (exp_awake) exp_q.push_back({a, b});
    dcc_source_i.send_pair(a, b);
  endtask : send
  task automatic test_reset();
    chk({ta, tb}, 24'h000000);
    chk({ca, cb}, 24'hffffff);
    chk({23'h0, awake}, 24'h000001);
    chk({23'h0, ovf}, 24'h000000);
  endtask : test_reset
  // Boundary codes back to back; last pair waits for the next rise
  task automatic test_stream();
    send(12'h000, 12'hfff);
    send(12'hfff, 12'h000);
    send(12'ha5c, 12'h5a3);
    chk(24'(exp_q.size()), 24'h000001);
    chk({23'h0, ovf}, 24'h000000);
  endtask : test_stream
  // Short pulse sends it to sleep and words are ignored; long ones wake it
  task automatic test_sleep();
    dcc_source_i.sleep_pulse(2);
    exp_awake = 1'b0;
    repeat (6) @(negedge clk);
    chk({23'h0, awake}, 24'h000000);
    send(12'h3c3, 12'hc3c);
    dcc_source_i.sleep_pulse(6);
    repeat (6) @(negedge clk);
    chk({23'h0, awake}, 24'h000001);
    dcc_source_i.sleep_pulse(2);
    repeat (6) @(negedge clk);
    chk({23'h0, awake}, 24'h000000);
    dcc_source_i.sleep_pulse(3);
    exp_awake = 1'b1;
    repeat (6) @(negedge clk);
    chk({23'h0, awake}, 24'h000001);
    dcc_source_i.release_sleep();
    repeat (6) @(negedge clk);
    send(12'h7ff, 12'h800);
    send(12'h001, 12'hffe);
    chk({23'h0, awake}, 24'h000001);
    chk(24'(exp_q.size()), 24'h000001);
    chk({23'h0, ovf}, 24'h000000);
  endtask : test_sleep
  // Reset while asleep: idle outputs, awake again, no stale pair left
  task automatic test_midreset();
    dcc_source_i.sleep_pulse(2);
    repeat (6) @(negedge clk);
    chk({23'h0, awake}, 24'h000000);
    rst = 1'b1;
    exp_q.delete();
    repeat (2) @(negedge clk);
    rst = 1'b0;
    test_reset();
    send(12'h123, 12'hedc);
    send(12'h456, 12'hba9);
    chk(24'(exp_q.size()), 24'h000001);
  endtask : test_midreset
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test
  // Whole run is about 130 cycles; this is far beyond it
  initial begin
    #200us;
    err_total++;
    finish_test();
  end
  initial begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    test_reset();
    test_stream();
    test_sleep();
    test_midreset();
    finish_test();
  end
endmodule : dcc_capture_tb
`default_nettype wire
